/* dv/pcio_board.sv */
/*
 * board model on the eight port pins.
 * assumes the board drives every pin that the port leaves undriven.
 */
`timescale 1ns/10ps
`default_nettype none

module pcio_board (
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] ext_i,
    output logic [7:0]      lvl_o
);
    // a driven pin shows the port's level, any other the board's
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : pcio_board

`default_nettype wire

/* dv/pcio_port_sva.sv */
/*
 * checker of the port block's bus answers and pin drive.
 * assumes hready_i is tied to hreadyout_o.
 */
`timescale 1ns/10ps
`default_nettype none

module pcio_port_chk #(
    parameter int unsigned HADDR_W = 32
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               hsel_i,
    input wire logic [HADDR_W-1:0] haddr_i,
    input wire logic [1:0]         htrans_i,
    input wire logic               hwrite_i,
    input wire logic [31:0]        hwdata_i,
    input wire logic               hready_i,
    input wire logic [31:0]        hrdata_o,
    input wire logic               hreadyout_o,
    input wire logic               hresp_o,
    input wire logic               hw_standby_i,
    input wire logic [3:0]         cs_n_i,
    input wire logic [7:0]         pin_i,
    input wire logic [7:0]         pin_o,
    input wire logic [7:0]         pin_oe_o
);
    logic        take;
    logic [15:0] idx;
    logic        wr_dir;
    logic        wr_dat;
    logic [7:0]  dir_sh;
    logic [7:0]  dat_sh;

    assign take = hsel_i & htrans_i[1] & hready_i;
    assign idx  = haddr_i[17:2];

    always_ff @(posedge clk_i) begin
        wr_dir <= !rst_i && take && hwrite_i && idx == pcio_pkg::DIR_INDEX;
        wr_dat <= !rst_i && take && hwrite_i && idx == pcio_pkg::DATA_INDEX;
    end

    // shadow copies: both registers clear on reset and hardware standby
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            dir_sh <= 8'h00;
            dat_sh <= 8'h00;
        end else begin
            if (wr_dir) dir_sh <= hwdata_i[7:0];
            if (wr_dat) dat_sh <= hwdata_i[7:0];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    dir_read_a: assert property (
        take && !hwrite_i && idx == pcio_pkg::DIR_INDEX
        |=> hrdata_o == 32'h0000_00FF) else $error("dir read not ones");
    dir_write_a: assert property (
        wr_dir && !hw_standby_i |=> ##[0:1] pin_oe_o == dir_sh)
        else $error("pin enables miss dir write");
    data_write_a: assert property (
        wr_dat && !hw_standby_i
        |=> ##[0:1] (pin_o & 8'hC3) == (dat_sh & 8'hC3))
        else $error("generic pins miss data write");
    cs_pins_a: assert property (
        !$past(rst_i) && !$past(hw_standby_i)
        |-> pin_o[5:2] == $past(cs_n_i)) else $error("cs pins wrong");
    standby_clr_a: assert property (
        hw_standby_i |=> pin_oe_o == 8'h00) else $error("standby kept oe");
    pin_read_a: assert property (
        take && !hwrite_i && idx == pcio_pkg::DATA_INDEX && !hw_standby_i
        && pin_oe_o == 8'h00 ##1 pin_oe_o == 8'h00
        |-> hrdata_o == {24'h000000, $past(pin_i)})
        else $error("input read not pin level");
    out_read_a: assert property (
        take && !hwrite_i && idx == pcio_pkg::DATA_INDEX && !wr_dat
        && !hw_standby_i && pin_oe_o == 8'hFF ##1 pin_oe_o == 8'hFF
        |-> hrdata_o[7:0] == dat_sh) else $error("output read not data");
    unmapped_a: assert property (
        take && !hwrite_i && idx != pcio_pkg::DIR_INDEX
        && idx != pcio_pkg::DATA_INDEX |=> hrdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (
        hrdata_o[31:8] == 24'h000000) else $error("read upper bits set");
    bus_answer_a: assert property (
        hreadyout_o && hresp_o == pcio_pkg::HRESP_OKAY)
        else $error("bus answer not ready okay");
endmodule : pcio_port_chk

bind pcio_port pcio_port_chk #(.HADDR_W(HADDR_W)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hw_standby_i(hw_standby_i), .cs_n_i(cs_n_i), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));

`default_nettype wire

/* dv/tb_port_c_io_port.sv */
/*
 * self-checking bench of the port block over AHB-Lite.
 * assumes the board model drives the pins the port leaves undriven.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_port_c_io_port;
    localparam logic [31:0] A_DIR = {14'h0000, pcio_pkg::DIR_INDEX, 2'b00};
    localparam logic [31:0] A_DAT = {14'h0000, pcio_pkg::DATA_INDEX, 2'b00};
    localparam logic [31:0] A_BAD = {14'h0000, 16'hFFD6, 2'b00};
    logic        clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic        hw_standby_i = 1'b0, hreadyout_o, hresp_o;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, d;
    logic [1:0]  htrans_i = 2'h0;
    logic [3:0]  cs_n_i = 4'hF;
    logic [7:0]  ext = 8'h00, pin_i, pin_o, pin_oe_o;
    int          err_count = 0, n_compared = 0;

    always #25 clk_i = ~clk_i;

    pcio_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hw_standby_i(hw_standby_i), .cs_n_i(cs_n_i), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    pcio_board i_board (.drv_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext),
        .lvl_o(pin_i));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        hwrite_i <= w;
        htrans_i <= 2'b10;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        d = hrdata_o;
    endtask : xfer
    task pins(input logic [7:0] oe, input logic [7:0] lvl);
        cyc(3);
        chk({24'h0, pin_oe_o}, {24'h0, oe});
        chk({24'h0, pin_o & 8'hC3}, {24'h0, lvl & 8'hC3});
        chk({28'h0, pin_o[5:2]}, {28'h0, cs_n_i});
    endtask : pins

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_reset;
        ext <= 8'h5A;
        pins(8'h00, 8'h00);
        xfer(1'b0, A_DAT, 32'h0);
        chk(d, 32'h0000_005A);
        xfer(1'b0, A_DIR, 32'h0);
        chk(d, 32'h0000_00FF);
        $display("t_reset done");
    endtask : t_reset
    task t_out;
        xfer(1'b1, A_DAT, 32'hFFFF_FFA5);
        xfer(1'b1, A_DIR, 32'h0000_00FF);
        cs_n_i <= 4'h6;
        pins(8'hFF, 8'hA5);
        xfer(1'b0, A_DAT, 32'h0);
        chk(d, 32'h0000_00A5);
        xfer(1'b0, A_DIR, 32'h0);
        chk(d, 32'h0000_00FF);
        cyc(20);
        pins(8'hFF, 8'hA5);
        $display("t_out done");
    endtask : t_out
    task t_mix;
        ext <= 8'hC3;
        xfer(1'b1, A_DIR, 32'h0000_000F);
        xfer(1'b1, A_DAT, 32'h0000_003C);
        xfer(1'b0, A_DAT, 32'h0);
        chk(d, 32'h0000_00CC);
        pins(8'h0F, 8'h3C);
        $display("t_mix done");
    endtask : t_mix
    task t_map;
        xfer(1'b1, A_BAD, 32'h0000_0055);
        xfer(1'b0, A_BAD, 32'h0);
        chk(d, 32'h0000_0000);
        xfer(1'b0, A_DAT | 32'h0004_0000, 32'h0);
        chk(d, 32'h0000_00CC);
        $display("t_map done");
    endtask : t_map
    task t_hws;
        hw_standby_i <= 1'b1;
        cyc(1);
        hw_standby_i <= 1'b0;
        pins(8'h00, 8'h00);
        xfer(1'b1, A_DIR, 32'h0000_00FF);
        xfer(1'b0, A_DAT, 32'h0);
        chk(d, 32'h0000_0000);
        $display("t_hws done");
    endtask : t_hws
    // mid-run reset must clear registers that hold non-zero values
    task t_rst;
        xfer(1'b1, A_DAT, 32'h0000_00C3);
        xfer(1'b1, A_DIR, 32'h0000_00FF);
        pins(8'hFF, 8'hC3);
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        cyc(1);
        pins(8'h00, 8'h00);
        xfer(1'b1, A_DIR, 32'h0000_00FF);
        xfer(1'b0, A_DAT, 32'h0);
        chk(d, 32'h0000_0000);
        $display("t_rst done");
    endtask : t_rst

    initial begin
        cyc(12);
        rst_i <= 1'b0;
        cyc(1);
        t_reset;
        t_out;
        t_mix;
        t_map;
        t_hws;
        t_rst;
        close_out;
    end

    initial begin
        cyc(2000);
        err_count++;
        close_out;
    end
endmodule : tb_port_c_io_port

`default_nettype wire

/* rtl/pcio_bus_front.sv */
/*
 * AHB-Lite address-phase decode and data-phase hold for the port block.
 * assumes hready is the block's own zero-wait hreadyout.
 */
`timescale 1ns/10ps
`default_nettype none

module pcio_bus_front #(
    parameter int unsigned HADDR_W = 32
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 hsel_i,
    input  wire logic [HADDR_W-1:0]   haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic                 hready_i,
    output pcio_pkg::pcio_access_t    addr_ph_o,
    output pcio_pkg::pcio_access_t    data_ph_o
);

    pcio_pkg::pcio_phase_t phase;
    logic                  take;

    // idle and busy transfers are answered but never decoded
    assign take = hsel_i & htrans_i[1] & hready_i;
    assign addr_ph_o.wr    = take & hwrite_i;
    assign addr_ph_o.rd    = take & ~hwrite_i;
    // only sixteen bits of the word address are compared
    assign addr_ph_o.index = haddr_i[pcio_pkg::IDX_MSB:pcio_pkg::IDX_LSB];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase     <= pcio_pkg::PCIO_PH_IDLE;
            data_ph_o <= '0;
        end else begin
            data_ph_o <= take ? addr_ph_o : '0;
            case (phase)
                pcio_pkg::PCIO_PH_IDLE: begin
                    if (take) begin
                        phase <= pcio_pkg::PCIO_PH_DATA;
                    end
                end
                pcio_pkg::PCIO_PH_DATA: begin
                    if (!take) begin
                        phase <= pcio_pkg::PCIO_PH_IDLE;
                    end
                end
                default: begin
                    phase <= pcio_pkg::PCIO_PH_IDLE;
                end
            endcase
        end
    end

endmodule : pcio_bus_front

`default_nettype wire

/* rtl/pcio_pin_drive.sv */
/*
 * registered pin driver: per-pin level and output enable.
 * assumes chip selects arrive active low from the bus controller.
 */
`timescale 1ns/10ps
`default_nettype none

module pcio_pin_drive (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               hw_standby_i,
    input  wire logic [7:0]         dir_i,
    input  wire logic [7:0]         data_i,
    input  wire logic [3:0]         cs_n_i,
    output pcio_pkg::pcio_drive_t   drive_o
);

    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            drive_o.oe <= '0;
        end else begin
            // a cleared bit releases its pin
            drive_o.oe <= dir_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_o.level <= pcio_pkg::DATA_RESET;
        end else begin
            // generic outputs follow the data register
            drive_o.level <= data_i;
            // pins 5..2 carry chip selects seven..four
            drive_o.level[pcio_pkg::CS_HI:pcio_pkg::CS_LO] <= cs_n_i;
        end
    end

endmodule : pcio_pin_drive

`default_nettype wire

/* rtl/pcio_pkg.sv */
/*
 * shared constants and carriers of the port C general-purpose i/o block.
 * assumes a 32-bit AHB-Lite bus and a synchronous 20 MHz system clock.
 */
package pcio_pkg;

    // ************************************************************
    // register map: word indices, byte address is four times these
    // ************************************************************
    localparam int unsigned PORT_W     = 8;
    localparam logic [15:0] DIR_INDEX  = 16'hFFD5;
    localparam logic [15:0] DATA_INDEX = 16'hFFD7;
    localparam int unsigned IDX_LSB    = 2;
    localparam int unsigned IDX_MSB    = 17;

    // ************************************************************
    // reset and read-back values
    // ************************************************************
    localparam logic [7:0]  DIR_RESET  = 8'h00;
    localparam logic [7:0]  DATA_RESET = 8'h00;
    localparam logic [7:0]  DIR_READ   = 8'hFF;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
    localparam logic        HRESP_OKAY = 1'b0;

    // ************************************************************
    // pin roles: pins 5..2 carry chip selects seven..four
    // ************************************************************
    localparam int unsigned CS_LO = 2;
    localparam int unsigned CS_HI = 5;

    typedef enum logic [1:0] {
        PCIO_PH_IDLE = 2'b01,
        PCIO_PH_DATA = 2'b10
    } pcio_phase_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
    } pcio_access_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe;
    } pcio_drive_t;

endpackage : pcio_pkg

/* rtl/pcio_port.sv */
/*
 * port C general-purpose i/o block: direction and data registers on
 * AHB-Lite, registered pin drive and a direction-steered port read.
 * assumes pins and standby level are synchronous to clk_i, and that the
 * bus controller supplies the four active-low chip selects.
 */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module pcio_port #(
    parameter int unsigned HADDR_W = 32
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    input  wire logic                hsel_i,
    input  wire logic [HADDR_W-1:0]  haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic [31:0]              hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    // ************************************************************
    // system and pins
    // ************************************************************
    input  wire logic                hw_standby_i,
    input  wire logic [3:0]          cs_n_i,
    input  wire logic [7:0]          pin_i,
    output logic [7:0]               pin_o,
    output logic [7:0]               pin_oe_o
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the word index needs address bits up to IDX_MSB
    if (HADDR_W <= pcio_pkg::IDX_MSB) begin : g_bad_addr_w
        $error("haddr too narrow for the port register index");
    end

    // ************************************************************
    // declarations
    // ************************************************************
    pcio_pkg::pcio_access_t  addr_ph;
    pcio_pkg::pcio_access_t  data_ph;
    pcio_pkg::pcio_drive_t   drive;

    logic [7:0]              port_c_direction;
    logic [7:0]              port_c_data;

    logic                    dir_wr;
    logic                    data_wr;
    logic [7:0]              wr_byte;

    logic [7:0]              fwd_direction;
    logic [7:0]              fwd_data;
    logic [31:0]             next_rdata;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic hit(
        input pcio_pkg::pcio_access_t acc,
        input logic [15:0]            index
    );
        return acc.index == index;
    endfunction : hit

    // each bit picks stored data or the live pin by its direction
    function automatic logic [7:0] port_view(
        input logic [7:0] dir,
        input logic [7:0] data,
        input logic [7:0] pins
    );
        // outputs read back stored data inputs the pin
        return (dir & data) | (~dir & pins);
    endfunction : port_view

    // ************************************************************
    // bus front end
    // ************************************************************
    pcio_bus_front #(
        .HADDR_W   (HADDR_W)
    ) u_front (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .hsel_i    (hsel_i),
        .haddr_i   (haddr_i),
        .htrans_i  (htrans_i),
        .hwrite_i  (hwrite_i),
        .hready_i  (hready_i),
        .addr_ph_o (addr_ph),
        .data_ph_o (data_ph)
    );

    // narrow data sits in byte lane 0, the rest is dropped
    assign wr_byte = hwdata_i[7:0];

    // the data-phase write lands on the edge that ends it
    assign dir_wr  = data_ph.wr & hit(data_ph, pcio_pkg::DIR_INDEX);
    assign data_wr = data_ph.wr & hit(data_ph, pcio_pkg::DATA_INDEX);

    // ************************************************************
    // direction register
    // ************************************************************
    // no standby-software input exists: holding is simply the
    // absence of any clear, so outputs stay driven
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            port_c_direction <= pcio_pkg::DIR_RESET;
        end else if (dir_wr) begin
            port_c_direction <= wr_byte;
        end
    end

    // ************************************************************
    // data register
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            port_c_data <= pcio_pkg::DATA_RESET;
        end else if (data_wr) begin
            port_c_data <= wr_byte;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    // read data is registered at the address-phase edge, so a read
    // that directly follows a write would see the old value; the
    // write still in its data phase is forwarded instead of adding
    // a wait state
    always_comb begin
        fwd_direction = port_c_direction;
        fwd_data      = port_c_data;
        if (dir_wr) begin
            fwd_direction = wr_byte;
        end
        if (data_wr) begin
            fwd_data = wr_byte;
        end
        if (hw_standby_i) begin
            fwd_direction = pcio_pkg::DIR_RESET;
            fwd_data      = pcio_pkg::DATA_RESET;
        end
    end

    always_comb begin
        next_rdata = pcio_pkg::RDATA_NONE;
        if (addr_ph.rd) begin
            if (hit(addr_ph, pcio_pkg::DIR_INDEX)) begin
                // write-only: the stored value never shows
                next_rdata[7:0] = pcio_pkg::DIR_READ;
            end else if (hit(addr_ph, pcio_pkg::DATA_INDEX)) begin
                next_rdata[7:0] = port_view(fwd_direction,
                                            fwd_data, pin_i);
            end
        end
    end

    // unmapped reads return zero, idle cycles clear the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_o <= pcio_pkg::RDATA_NONE;
        end else begin
            hrdata_o <= next_rdata;
        end
    end

    // ************************************************************
    // bus handshake
    // ************************************************************
    // zero wait states, every access answers OKAY
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= pcio_pkg::HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= pcio_pkg::HRESP_OKAY;
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    // no mode input reaches the pin logic: pin roles are fixed
    pcio_pin_drive u_drive (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .hw_standby_i (hw_standby_i),
        .dir_i        (port_c_direction),
        .data_i       (port_c_data),
        .cs_n_i       (cs_n_i),
        .drive_o      (drive)
    );

    // both come from flops inside the drive stage
    assign pin_o    = drive.level;
    assign pin_oe_o = drive.oe;

endmodule : pcio_port

`default_nettype wire
